// [hw/lps_config_regs.sv]
// Configuration bank of the light/proximity sensor, I2C slave included.
// Assumes the analog side reports each conversion by a convDone pulse
// on clk, with threshold hits and the raw ambient level valid with it.
//
// Contract
// [R1] Identity register: fixed five-bit code, bits 7:3
// [R2] Bit 5 of 0x01 enables proximity
// [R3] Idle interval field selects wait between measurements
// [R4] Emitter current field selects LED pulse current
// [R5] Bit 7 of 0x02 picks threshold scheme
// [R6] Bits 6:3 of 0x02 hold offset trim
// [R7] Bit 2 of 0x02 enables light sensing
// [R8] Bits 1:0 of 0x02 select light range
// [R9] Register 0x03 holds five-bit infrared trim
// [R10] Interrupt register resets to 0x10
// [R11] Ambient infrared level saturates at 127
// [R12] Saturation flag set near 90 percent
// [R13] Slave address 1000100, no repeated start
// [R14] Persistence: 1, 2, 4, 8 consecutive events
// [R15] Bit 0 chooses AND or OR interrupt
// [R16] Reserved bits ignore writes, read zero
// [R17] Config changes apply at next measurement start; register 0x04 fields are used live, not copied at start
`timescale 1ns/100ps
module lps_config_regs
  import lps_pkg::*;
#(
  parameter int unsigned TICK_CYCLES   = LPS_IDLE_UNIT_CYC,
  parameter logic [4:0]  IDENTITY_CODE = 5'h0A  // Arbitrary value
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic       convDone,
  input  wire logic       proxHit,
  input  wire logic       lightHit,
  input  wire logic [7:0] ambientRaw,
  input  wire logic       brownOut,
  output logic            measStart,
  output logic            proximityOn,
  output logic [2:0]      proximityIdleInterval,
  output logic [1:0]      emitterCurrentSel,
  output logic            thresholdScheme,
  output logic [3:0]      reflectionOffsetTrim,
  output logic            lightSenseOn,
  output logic [1:0]      lightFullscaleSel,
  output logic [4:0]      lightInfraredTrim,
  output logic            intOutN
);
  import lps_pkg::*;

  typedef struct packed {
    logic [2:0] sclSync;
    logic [2:0] sdaSync;
    logic       sclFilt;
    logic       sdaFilt;
    lps_i2c_t   bus;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic       rw;
    logic       nack;
    logic       drive;
    logic [7:0] ptr;
    logic [5:0] proxSetup;
    logic [7:0] plSetup;
    logic [4:0] irTrim;
    logic [1:0] proxPers;
    logic [1:0] lightPers;
    logic       combine;
    logic       proxFlag;
    logic       lightFlag;
    logic       pwrFail;
    logic [6:0] ambient;
    logic [3:0] proxCnt;
    logic [3:0] lightCnt;
    lps_seq_t   seq;
    logic [19:0] tickCnt;
    logic [7:0] idleCnt;
    logic       launch;
    logic [5:0] appProx;
    logic [7:0] appPl;
    logic [4:0] appIr;
  } lps_state_t;

  lps_state_t st_reg;
  lps_state_t st_next;

  function automatic logic [7:0] readByte(input logic [7:0] a,
                                          input lps_state_t s);
    logic [7:0] v;
    v = 8'h00;
    if (a == LPS_OFF_IDENT) begin
      v = {IDENTITY_CODE, 3'b000};                               // [R1]
    end else if (a == LPS_OFF_PROX) begin
      v = {2'b00, s.proxSetup};                                  // [R16]
    end else if (a == LPS_OFF_PROXLIGHT) begin
      v = s.plSetup;
    end else if (a == LPS_OFF_IRTRIM) begin
      v = {3'b000, s.irTrim};                                    // [R9]
    end else if (a == LPS_OFF_INTR) begin
      v = {s.proxFlag, s.proxPers, s.pwrFail, s.lightFlag,
           s.lightPers, s.combine};
    end else if (a == LPS_OFF_AMBIENT) begin
      v = {s.ambient, s.ambient >= LPS_AMB_SAT_LEVEL};           // [R12]
    end
    return v;
  endfunction

  logic       sclRise;
  logic       sclFall;
  logic       busStart;
  logic       busStop;
  logic [3:0] proxTarget;
  logic [3:0] lightTarget;
  logic [3:0] proxCntInc;
  logic [3:0] lightCntInc;
  logic       anyOn;

  // ==========================================================
  // Next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.launch = 1'b0;
    // Three-stage synchronisers; a change counts when stages 2 and 3 agree
    st_next.sclSync = {st_reg.sclSync[1:0], sclIn};
    st_next.sdaSync = {st_reg.sdaSync[1:0], sdaIn};
    if (st_reg.sclSync[1] == st_reg.sclSync[2])
      st_next.sclFilt = st_reg.sclSync[2];
    if (st_reg.sdaSync[1] == st_reg.sdaSync[2])
      st_next.sdaFilt = st_reg.sdaSync[2];
    sclRise  = st_next.sclFilt & ~st_reg.sclFilt;
    sclFall  = ~st_next.sclFilt & st_reg.sclFilt;
    busStart = st_reg.sclFilt & st_next.sclFilt &
               st_reg.sdaFilt & ~st_next.sdaFilt;
    busStop  = st_reg.sclFilt & st_next.sclFilt &
               ~st_reg.sdaFilt & st_next.sdaFilt;

    // ========================================================
    // I2C slave
    if (busStop) begin
      st_next.bus = I2C_IDLE;
      st_next.drive = 1'b0;
    end else if (busStart) begin
      // A start inside a frame just restarts address decode
      st_next.bus = I2C_ADDR;                                    // [R13]
      st_next.bitCnt = 4'h0;
      st_next.drive = 1'b0;
    end else if (sclRise) begin
      case (st_reg.bus)
        I2C_ADDR, I2C_WREG, I2C_WDATA: begin
          st_next.shift = {st_reg.shift[6:0], st_reg.sdaFilt};
          st_next.bitCnt = st_reg.bitCnt + 4'h1;
        end
        I2C_RACK: st_next.nack = st_reg.sdaFilt;
        default: ;
      endcase
    end else if (sclFall) begin
      case (st_reg.bus)
        I2C_ADDR: begin
          if (st_reg.bitCnt == 4'h8) begin
            if (st_reg.shift[7:1] == LPS_SLAVE_ADDR) begin       // [R13]
              st_next.bus = I2C_ADDR_ACK;
              st_next.rw = st_reg.shift[0];
              st_next.drive = 1'b1;
            end else begin
              st_next.bus = I2C_IDLE;
            end
          end
        end
        I2C_ADDR_ACK: begin
          st_next.bitCnt = 4'h0;
          if (st_reg.rw) begin
            st_next.tx = readByte(st_reg.ptr, st_reg);
            st_next.drive = ~st_next.tx[7];
            st_next.bus = I2C_RDATA;
          end else begin
            st_next.drive = 1'b0;
            st_next.bus = I2C_WREG;
          end
        end
        I2C_WREG: begin
          if (st_reg.bitCnt == 4'h8) begin
            st_next.ptr = st_reg.shift;
            st_next.drive = 1'b1;
            st_next.bus = I2C_WREG_ACK;
          end
        end
        I2C_WDATA: begin
          if (st_reg.bitCnt == 4'h8) begin
            if (st_reg.ptr == LPS_OFF_PROX) begin
              st_next.proxSetup = st_reg.shift[5:0];             // [R16]
            end else if (st_reg.ptr == LPS_OFF_PROXLIGHT) begin
              st_next.plSetup = st_reg.shift;
            end else if (st_reg.ptr == LPS_OFF_IRTRIM) begin
              st_next.irTrim = st_reg.shift[4:0];                // [R9]
            end else if (st_reg.ptr == LPS_OFF_INTR) begin
              st_next.proxPers = st_reg.shift[LPS_PPERS_LSB +: 2];
              st_next.lightPers = st_reg.shift[LPS_LPERS_LSB +: 2];
              st_next.combine = st_reg.shift[LPS_COMBINE_BIT];
              // Flags clear on a written zero; set below wins
              st_next.proxFlag &= st_reg.shift[LPS_PFLAG_BIT];
              st_next.lightFlag &= st_reg.shift[LPS_LFLAG_BIT];
              st_next.pwrFail &= st_reg.shift[LPS_PWRFAIL_BIT];
            end
            st_next.ptr = st_reg.ptr + 8'h01;
            st_next.drive = 1'b1;
            st_next.bus = I2C_WDATA_ACK;
          end
        end
        I2C_WREG_ACK, I2C_WDATA_ACK: begin
          st_next.bitCnt = 4'h0;
          st_next.drive = 1'b0;
          st_next.bus = I2C_WDATA;
        end
        I2C_RDATA: begin
          if (st_reg.bitCnt == 4'h7) begin
            st_next.drive = 1'b0;
            st_next.ptr = st_reg.ptr + 8'h01;
            st_next.bus = I2C_RACK;
          end else begin
            st_next.bitCnt = st_reg.bitCnt + 4'h1;
            st_next.tx = {st_reg.tx[6:0], 1'b0};
            st_next.drive = ~st_reg.tx[6];
          end
        end
        I2C_RACK: begin
          if (st_reg.nack) begin
            st_next.bus = I2C_IDLE;
          end else begin
            st_next.bitCnt = 4'h0;
            st_next.tx = readByte(st_reg.ptr, st_reg);
            st_next.drive = ~st_next.tx[7];
            st_next.bus = I2C_RDATA;
          end
        end
        default: ;
      endcase
    end

    // ========================================================
    // Measurement sequencer; settings are copied only at launch
    anyOn = st_reg.proxSetup[LPS_PROX_ON_BIT] |
            st_reg.plSetup[LPS_LIGHT_ON_BIT];
    case (st_reg.seq)
      SEQ_OFF: begin
        if (anyOn) st_next.launch = 1'b1;
      end
      SEQ_CONV: begin
        if (convDone) begin
          // Code 0 is four times code 1; codes 1 to 6 halve from 32
          st_next.idleCnt = (st_reg.appProx[LPS_IDLE_LSB +: 3] == 3'b111) ?
            8'h00 : (st_reg.appProx[LPS_IDLE_LSB +: 3] == 3'b000) ?
            LPS_IDLE_MAX_UNITS : (LPS_IDLE_MAX_UNITS >>
            (4'(st_reg.appProx[LPS_IDLE_LSB +: 3]) + 4'h1));     // [R3]
          st_next.tickCnt = 20'h0_0000;
          if (st_next.idleCnt == 8'h00) begin
            st_next.launch = anyOn;
            st_next.seq = anyOn ? SEQ_CONV : SEQ_OFF;
          end else begin
            st_next.seq = SEQ_SLEEP;
          end
        end
      end
      SEQ_SLEEP: begin
        if (st_reg.tickCnt == 20'(TICK_CYCLES - 1)) begin
          st_next.tickCnt = 20'h0_0000;
          st_next.idleCnt = st_reg.idleCnt - 8'h01;
          if (st_reg.idleCnt == 8'h01) begin
            st_next.launch = anyOn;
            st_next.seq = anyOn ? SEQ_CONV : SEQ_OFF;
          end
        end else begin
          st_next.tickCnt = st_reg.tickCnt + 20'h0_0001;
        end
      end
      default: st_next.seq = SEQ_OFF;
    endcase
    if (st_next.launch) begin
      st_next.seq = SEQ_CONV;
      st_next.appProx = st_reg.proxSetup;                        // [R17]
      st_next.appPl = st_reg.plSetup;
      st_next.appIr = st_reg.irTrim;
    end

    // ========================================================
    // Conversion results, persistence and sticky flags
    proxTarget = 4'h1 << st_reg.proxPers;                        // [R14]
    lightTarget = 4'h1 << st_reg.lightPers;
    proxCntInc = (st_reg.proxCnt == LPS_PERS_MAX) ?
                 LPS_PERS_MAX : st_reg.proxCnt + 4'h1;
    lightCntInc = (st_reg.lightCnt == LPS_PERS_MAX) ?
                  LPS_PERS_MAX : st_reg.lightCnt + 4'h1;
    if (convDone && st_reg.seq == SEQ_CONV) begin
      // Clamp rather than wrap: a washed-out reading stays at full scale
      st_next.ambient = (ambientRaw > {1'b0, LPS_AMB_MAX}) ?
                        LPS_AMB_MAX : ambientRaw[6:0];           // [R11]
      if (st_reg.appProx[LPS_PROX_ON_BIT] && proxHit) begin
        st_next.proxCnt = proxCntInc;
        if (proxCntInc >= proxTarget) st_next.proxFlag = 1'b1;   // [R14]
      end else begin
        st_next.proxCnt = 4'h0;
      end
      if (st_reg.appPl[LPS_LIGHT_ON_BIT] && lightHit) begin
        st_next.lightCnt = lightCntInc;
        if (lightCntInc >= lightTarget) st_next.lightFlag = 1'b1;
      end else begin
        st_next.lightCnt = 4'h0;
      end
    end
    if (brownOut) st_next.pwrFail = 1'b1;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.sclSync <= 3'b111;
      st_reg.sdaSync <= 3'b111;
      st_reg.sclFilt <= 1'b1;
      st_reg.sdaFilt <= 1'b1;
      st_reg.bus <= I2C_IDLE;
      st_reg.seq <= SEQ_OFF;
      st_reg.proxSetup <= LPS_RST_PROX[5:0];                     // [R2]
      st_reg.plSetup <= LPS_RST_PROXLIGHT;                       // [R7]
      st_reg.irTrim <= LPS_RST_IRTRIM;
      {st_reg.proxFlag, st_reg.proxPers, st_reg.pwrFail, st_reg.lightFlag,
       st_reg.lightPers, st_reg.combine} <= LPS_RST_INTR;        // [R10]
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs
  assign sdaOut = 1'b0;
  assign sdaOe = st_reg.drive;
  assign measStart = st_reg.launch;
  assign proximityOn = st_reg.appProx[LPS_PROX_ON_BIT];          // [R2]
  assign proximityIdleInterval = st_reg.appProx[LPS_IDLE_LSB +: 3];
  assign emitterCurrentSel = st_reg.appProx[LPS_EMIT_LSB +: 2];  // [R4]
  assign thresholdScheme = st_reg.appPl[LPS_SCHEME_BIT];         // [R5]
  assign reflectionOffsetTrim = st_reg.appPl[LPS_OFFSET_LSB +: 4]; // [R6]
  assign lightSenseOn = st_reg.appPl[LPS_LIGHT_ON_BIT];          // [R7]
  assign lightFullscaleSel = st_reg.appPl[LPS_RANGE_LSB +: 2];   // [R8]
  assign lightInfraredTrim = st_reg.appIr;                       // [R9]
  assign intOutN = st_reg.combine ?
                   ~(st_reg.proxFlag & st_reg.lightFlag) :
                   ~(st_reg.proxFlag | st_reg.lightFlag);        // [R15]

  // ==========================================================
  // Checks
  a_intr_reset: assert property (@(posedge clk)                  // [R10]
    $past(rst) && !rst |-> readByte(LPS_OFF_INTR, st_reg) == 8'h10)
    else $error("interrupt register reset value wrong");
  a_apply_launch: assert property (@(posedge clk) disable iff (rst) // [R17]
    $changed(proximityOn) || $changed(lightFullscaleSel) |->
    $past(st_next.launch))
    else $error("setting applied outside a launch");
  a_sat_clamp: assert property (@(posedge clk) disable iff (rst)  // [R11]
    convDone && st_reg.seq == SEQ_CONV && ambientRaw[7] |=>
    st_reg.ambient == 7'h7F)
    else $error("ambient level not clamped");
  a_sat_flag: assert property (@(posedge clk) disable iff (rst)   // [R12]
    convDone && st_reg.seq == SEQ_CONV && ambientRaw == 8'h73 |=>
    readByte(LPS_OFF_AMBIENT, st_reg) == 8'hE7)
    else $error("saturation flag not raised");
  a_pers_single: assert property (@(posedge clk) disable iff (rst) // [R14]
    convDone && st_reg.seq == SEQ_CONV && proxHit && proximityOn &&
    st_reg.proxPers == 2'b00 |=> st_reg.proxFlag)
    else $error("single event did not flag");
  a_int_combine: assert property (@(posedge clk) disable iff (rst) // [R15]
    st_reg.combine && !st_reg.lightFlag |-> intOutN)
    else $error("AND mode fired on one event");
  a_addr_ack: assert property (@(posedge clk) disable iff (rst)   // [R13]
    st_reg.bus == I2C_ADDR_ACK |-> sdaOe &&
    $past(st_reg.shift[7:1], 1) == 7'h44)
    else $error("acknowledge on foreign address");
  a_no_wait: assert property (@(posedge clk) disable iff (rst)    // [R3]
    st_reg.seq == SEQ_CONV && convDone && anyOn &&
    st_reg.appProx[LPS_IDLE_LSB +: 3] == 3'b111 |=> measStart)
    else $error("zero idle interval waited");
  a_ident_read: assert property (@(posedge clk) disable iff (rst) // [R1]
    st_reg.bus == I2C_ADDR_ACK && st_reg.rw && sclFall &&
    st_reg.ptr == LPS_OFF_IDENT |=>
    st_reg.tx == {IDENTITY_CODE, 3'b000})
    else $error("identity register wrong");

endmodule // lps_config_regs

// [hw/lps_pkg.sv]
// Constants and types for the light/proximity sensor configuration bank.
// Assumes a 100 MHz system clock and an I2C master on SCL/SDA.
package lps_pkg;

  // ==========================================================
  // Bus address and register offsets
  localparam logic [6:0] LPS_SLAVE_ADDR    = 7'h44;
  localparam logic [7:0] LPS_OFF_IDENT     = 8'h00;
  localparam logic [7:0] LPS_OFF_PROX      = 8'h01;
  localparam logic [7:0] LPS_OFF_PROXLIGHT = 8'h02;
  localparam logic [7:0] LPS_OFF_IRTRIM    = 8'h03;
  localparam logic [7:0] LPS_OFF_INTR      = 8'h04;
  localparam logic [7:0] LPS_OFF_AMBIENT   = 8'h0D;

  // ==========================================================
  // Reset values
  localparam logic [7:0] LPS_RST_PROX      = 8'h00;
  localparam logic [7:0] LPS_RST_PROXLIGHT = 8'h00;
  localparam logic [4:0] LPS_RST_IRTRIM    = 5'h00;
  localparam logic [7:0] LPS_RST_INTR      = 8'h10;

  // ==========================================================
  // Field positions
  localparam int LPS_PROX_ON_BIT    = 5;
  localparam int LPS_IDLE_LSB       = 2;
  localparam int LPS_EMIT_LSB       = 0;
  localparam int LPS_SCHEME_BIT     = 7;
  localparam int LPS_OFFSET_LSB     = 3;
  localparam int LPS_LIGHT_ON_BIT   = 2;
  localparam int LPS_RANGE_LSB      = 0;
  localparam int LPS_PFLAG_BIT      = 7;
  localparam int LPS_PPERS_LSB      = 5;
  localparam int LPS_PWRFAIL_BIT    = 4;
  localparam int LPS_LFLAG_BIT      = 3;
  localparam int LPS_LPERS_LSB      = 1;
  localparam int LPS_COMBINE_BIT    = 0;
  localparam int LPS_IDENT_LSB      = 3;

  // ==========================================================
  // Ambient level limits: 90 % of 127 rounded up
  localparam logic [6:0] LPS_AMB_MAX       = 7'h7F;
  localparam logic [6:0] LPS_AMB_SAT_LEVEL = 7'h73;

  // ==========================================================
  // Timing: idle interval unit is the shortest nonzero interval (code 6), 3.125 ms
  localparam int LPS_CLK_PERIOD_NS = 10;
  localparam int LPS_IDLE_UNIT_NS  = 3125000;
  localparam int LPS_IDLE_UNIT_CYC = LPS_IDLE_UNIT_NS / LPS_CLK_PERIOD_NS;
  localparam logic [7:0] LPS_IDLE_MAX_UNITS = 8'h80;
  localparam logic [3:0] LPS_PERS_MAX       = 4'h8;

  // ==========================================================
  // State encodings
  typedef enum logic [3:0] {
    I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_WREG, I2C_WREG_ACK,
    I2C_WDATA, I2C_WDATA_ACK, I2C_RDATA, I2C_RACK
  } lps_i2c_t;

  typedef enum logic [1:0] {SEQ_OFF, SEQ_CONV, SEQ_SLEEP} lps_seq_t;

endpackage

// [test/lps_host_model.sv]
// Host side I2C master model driving SCL and pulling SDA low.
// Assumes the bench resolves SDA with a pull-up and feeds it back.
`timescale 1ns/100ps
module lps_host_model #(
  parameter int HALF = 10
) (
  input  wire logic clk,
  input  wire logic sdaLine,
  output logic      scl,
  output logic      sdaPull
);
  import lps_pkg::*;

  initial begin
    scl     = 1'b1;
    sdaPull = 1'b0;
  end

  // ==========================================================
  // Bit level
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Data moves only in the low phase, read back mid-high
  task automatic bit_cycle(input logic b, output logic r);
    sdaPull = !b;
    wait_clk(HALF);
    scl = 1'b1;
    wait_clk(HALF / 2);
    r = sdaLine;
    wait_clk(HALF - HALF / 2);
    scl = 1'b0;
    wait_clk(2);
  endtask

  task automatic start_cond();
    sdaPull = 1'b1;
    wait_clk(HALF);
    scl = 1'b0;
    wait_clk(2);
  endtask

  task automatic stop_cond();
    sdaPull = 1'b1;
    wait_clk(HALF);
    scl = 1'b1;
    wait_clk(HALF);
    sdaPull = 1'b0;
    wait_clk(2 * HALF);
  endtask

  // ==========================================================
  // Byte level
  task automatic send_byte(input logic [7:0] b, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(b[i], r);
    end
    bit_cycle(1'b1, nack);
  endtask

  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, r);
      b[i] = r;
    end
    bit_cycle(last, r);
  endtask

  // Every transfer closed by a stop, never a repeated start
  task automatic write_regs(input logic [6:0] dev, input logic [7:0] ptr,
                            input logic [23:0] data, input int n,
                            output logic addrNack);
    logic nk;
    start_cond();
    send_byte({dev, 1'b0}, addrNack);
    send_byte(ptr, nk);
    for (int k = 0; k < n; k++) begin
      send_byte(data[23 - 8 * k -: 8], nk);
    end
    stop_cond();
  endtask

  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d);
    logic nk;
    write_regs(LPS_SLAVE_ADDR, ptr, 24'h00_0000, 0, nk);
    start_cond();
    send_byte({LPS_SLAVE_ADDR, 1'b1}, nk);
    recv_byte(1'b1, d);
    stop_cond();
  endtask
endmodule // lps_host_model

// [test/tb_top.sv]
// Self-checking bench for the sensor configuration bank.
// Assumes the host model as I2C master and plays the analog side here.
`timescale 1ns/100ps
module tb_top;
  import lps_pkg::*;
  localparam int         TICK  = 4;
  localparam logic [4:0] IDC   = 5'h0A; // Arbitrary identity value
  localparam int         LIMIT = 80000;

  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       convDone = 1'b0;
  logic       proxHit = 1'b0;
  logic       lightHit = 1'b0;
  logic [7:0] ambientRaw = 8'h00;
  logic       brownOut = 1'b0;
  logic       scl, sdaPull, sdaOut, sdaOe, measStart, intOutN, nk;
  logic       proximityOn, thresholdScheme, lightSenseOn;
  logic [2:0] proximityIdleInterval;
  logic [1:0] emitterCurrentSel, lightFullscaleSel;
  logic [3:0] reflectionOffsetTrim;
  logic [4:0] lightInfraredTrim;
  logic [7:0] d;
  wire logic  sdaLine = !(sdaPull || (sdaOe && !sdaOut));
  int num_errors = 0, num_checks = 0, cyc = 0, starts = 0, used = 0;
  int doneCyc = 0, gap = 0, u;
  int idleCodes [5] = '{6, 5, 1, 0, 7};

  always #5 clk = ~clk;

  lps_config_regs #(.TICK_CYCLES(TICK), .IDENTITY_CODE(IDC))
    lps_config_regs_i (
    .clk(clk), .rst(rst), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .convDone(convDone), .proxHit(proxHit),
    .lightHit(lightHit), .ambientRaw(ambientRaw), .brownOut(brownOut),
    .measStart(measStart), .proximityOn(proximityOn),
    .proximityIdleInterval(proximityIdleInterval),
    .emitterCurrentSel(emitterCurrentSel), .thresholdScheme(thresholdScheme),
    .reflectionOffsetTrim(reflectionOffsetTrim), .lightSenseOn(lightSenseOn),
    .lightFullscaleSel(lightFullscaleSel),
    .lightInfraredTrim(lightInfraredTrim), .intOutN(intOutN));

  lps_host_model lps_host_model_i (
    .clk(clk), .sdaLine(sdaLine), .scl(scl), .sdaPull(sdaPull));

  // ==========================================================
  // Helpers
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (convDone) doneCyc <= cyc;
    if (measStart === 1'b1) begin
      starts <= starts + 1;
      gap    <= cyc - doneCyc;
    end
    if (cyc == LIMIT) begin
      num_errors = num_errors + 1;
      conclude();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s seen %h want %h", $time, what,
               seen, exp);
    end
  endtask

  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    lps_host_model_i.read_reg(ptr, d);
    check(d, exp, "register read");
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [23:0] v, input int n);
    lps_host_model_i.write_regs(LPS_SLAVE_ADDR, ptr, v, n, nk);
    check({7'b0, nk}, 8'h00, "address ack");
  endtask

  // Pending start stays unconsumed so a later convert still sees it
  task automatic wait_start();
    int n;
    n = 0;
    while (starts <= used && n < 3000) begin
      @(negedge clk);
      n++;
    end
    check({7'b0, starts > used}, 8'h01, "measurement start");
  endtask

  task automatic convert(input logic p, input logic l, input logic [7:0] a);
    wait_start();
    used = starts;
    repeat (3) @(negedge clk);
    {proxHit, lightHit, ambientRaw} = {p, l, a};
    convDone = 1'b1;
    @(negedge clk);
    convDone = 1'b0;
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    rd(LPS_OFF_IDENT, {IDC, 3'b000});
    rd(LPS_OFF_PROX, 8'h00);
    rd(LPS_OFF_PROXLIGHT, 8'h00);
    rd(LPS_OFF_IRTRIM, 8'h00);
    rd(LPS_OFF_INTR, 8'h10);
    rd(8'h20, 8'h00);
    $display("test reset values done");
    wr(LPS_OFF_PROX, 24'hFF_FFFF, 3);
    rd(LPS_OFF_PROX, 8'h3F);
    rd(LPS_OFF_PROXLIGHT, 8'hFF);
    rd(LPS_OFF_IRTRIM, 8'h1F);
    lps_host_model_i.write_regs(7'h45, LPS_OFF_PROX, 24'h0, 1, nk);
    check({7'b0, nk}, 8'h01, "foreign address");
    rd(LPS_OFF_PROX, 8'h3F);
    $display("test access kinds done");
    wr(LPS_OFF_PROX, 24'h3E_0000, 3);
    convert(1'b0, 1'b0, 8'h00);
    wait_start();
    check({7'b0, proximityOn}, 8'h01, "prox on");
    check({5'b0, proximityIdleInterval}, 8'h07, "idle");
    check({6'b0, emitterCurrentSel}, 8'h02, "emitter");
    wr(LPS_OFF_PROXLIGHT, 24'hAD_1500, 2);
    check({7'b0, lightSenseOn}, 8'h00, "held light on");
    check({6'b0, lightFullscaleSel}, 8'h00, "held range");
    convert(1'b0, 1'b0, 8'h00);
    wait_start();
    check({7'b0, thresholdScheme}, 8'h01, "scheme");
    check({4'b0, reflectionOffsetTrim}, 8'h05, "offset");
    check({7'b0, lightSenseOn}, 8'h01, "light on");
    check({6'b0, lightFullscaleSel}, 8'h01, "range");
    check({3'b0, lightInfraredTrim}, 8'h15, "ir trim");
    for (int c = 0; c < 4; c++) begin
      wr(LPS_OFF_PROX, {6'b001111, c[1:0], 6'b000001, c[1:0], 8'h00}, 2);
      convert(1'b0, 1'b0, 8'h00);
      wait_start();
      check({6'b0, emitterCurrentSel}, {6'b0, c[1:0]}, "emitter");
      check({6'b0, lightFullscaleSel}, {6'b0, c[1:0]}, "range");
    end
    $display("test applied settings done");
    foreach (idleCodes[k]) begin
      wr(LPS_OFF_PROX, {3'b001, idleCodes[k][2:0], 18'h0}, 1);
      convert(1'b0, 1'b0, 8'h00);
      convert(1'b0, 1'b0, 8'h00);
      wait_start();
      u = (idleCodes[k] == 0) ? 128 : (idleCodes[k] == 7) ? 0
          : 64 >> idleCodes[k];
      check({7'b0, gap >= u * TICK - 1 && gap <= u * TICK + 3}, 8'h01,
            "idle gap");
    end
    $display("test idle interval done");
    for (int c = 0; c < 4; c++) begin
      wr(LPS_OFF_INTR, {1'b0, c[1:0], 2'b00, c[1:0], 1'b0, 16'h0}, 1);
      convert(1'b0, 1'b0, 8'h00);
      repeat ((1 << c) - 1) convert(1'b1, c > 0, 8'h00);
      if (c > 0) rd(LPS_OFF_INTR, {1'b0, c[1:0], 2'b00, c[1:0], 1'b0});
      convert(1'b1, c > 0, 8'h00);
      rd(LPS_OFF_INTR, {1'b1, c[1:0], 1'b0, c > 0, c[1:0], 1'b0});
      check({7'b0, intOutN}, 8'h00, "int either");
    end
    wr(LPS_OFF_INTR, 24'h01_0000, 1);
    convert(1'b0, 1'b0, 8'h00);
    convert(1'b1, 1'b0, 8'h00);
    check({7'b0, intOutN}, 8'h01, "int needs both");
    convert(1'b0, 1'b1, 8'h00);
    rd(LPS_OFF_INTR, 8'h89);
    brownOut = 1'b1;
    @(negedge clk);
    brownOut = 1'b0;
    rd(LPS_OFF_INTR, 8'h99);
    check({7'b0, intOutN}, 8'h00, "int both");
    $display("test interrupt flags done");
    convert(1'b0, 1'b0, 8'hC8);
    rd(LPS_OFF_AMBIENT, 8'hFF);
    convert(1'b0, 1'b0, 8'h7F);
    rd(LPS_OFF_AMBIENT, 8'hFF);
    convert(1'b0, 1'b0, 8'h64);
    rd(LPS_OFF_AMBIENT, 8'hC8);
    $display("test ambient level done");
    conclude();
  end
endmodule // tb_top
